// [dcp_cfg.svh]
// constants for the direct channel parallel output port
// assumes a 20 MHz system clock; one computer cycle is eight phase slots
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH
`define DCP_CW 24
`define DCP_PH_W 3
`define DCP_PH_T0 3'h0
`define DCP_PH_T3 3'h3
`define DCP_PH_T4 3'h4
`define DCP_PH_T5 3'h5
`define DCP_PH_T6 3'h6
`define DCP_PH_T7 3'h7
`define DCP_STROBE_PH 3'h2
`define DCP_SEL_B1 1
`define DCP_SEL_B10 10
`define DCP_SEL_B17 17
`define DCP_C_RST 24'h000000
`endif

// [dcp_pkg.sv]
// types for the direct channel parallel output port
// assumes dcp_cfg.svh is included by the design files
package dcp_pkg;
    typedef enum logic [2:0] {
        OP_IDLE, OP_OUT_WAIT, OP_IN_WAIT, OP_IN_DONE, OP_DIRECT, OP_SKIP
    } op_state_t;
    typedef enum logic [1:0] {
        MODE_IO, MODE_BUFFER, MODE_SYSTEM
    } direct_mode_t;
    typedef enum logic {
        SKIP_UNIT, SKIP_SYSTEM
    } skip_kind_t;
endpackage : dcp_pkg

// [dcp_port.sv]
// computer-side parallel output and control port of the direct channel
// assumes the processor issues one instruction at a time via i_op_* pulses
`timescale 1ns/10ps
`include "dcp_cfg.svh"
module dcp_port
    import dcp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_op_pot,
    input wire logic i_op_pin,
    input wire logic i_op_direct,
    input wire logic i_op_skip,
    input wire direct_mode_t i_direct_mode,
    input wire skip_kind_t i_skip_kind,
    input wire logic [23:0] i_c_word,
    input wire logic i_companion_conn,
    input wire logic i_tape_gap,
    input wire logic i_start_button,
    input wire logic i_external_ready_n,
    input wire logic i_unit_skip_n,
    input wire logic i_system_skip_n,
    input wire logic [23:0] i_in_data_n,
    output logic o_busy,
    output logic o_done,
    output logic o_skip_next,
    output logic [23:0] o_c_reg_in,
    output logic o_pot_wait,
    output logic o_pot_strobe,
    output logic o_pin_strobe,
    output logic o_direct_io_mode_strobe,
    output logic o_direct_buffer_strobe,
    output logic o_direct_system_strobe,
    output logic o_direct_common_strobe,
    output logic o_phase_timing_a,
    output logic o_phase_timing_b,
    output logic o_phase_c_or_gap,
    output logic o_pin_terminated_n,
    output logic o_skip_test_strobe,
    output logic o_start_reset_out,
    output logic o_device_select,
    output logic [23:0] o_c_lines
);
    op_state_t state_q;
    op_state_t state_d;
    logic [2:0] phase_q;
    logic [23:0] c_q;
    logic skip_kind_sys_q;
    direct_mode_t mode_q;
    logic ready;
    logic unit_skip;
    logic sys_skip;
    logic skip_seen_q;
    logic skip_seen_d;
    wire strobe_slot = (phase_q == `DCP_STROBE_PH);
    wire in_out_wait = (state_q == OP_OUT_WAIT);
    wire in_in_wait = (state_q == OP_IN_WAIT);
    wire in_skip = (state_q == OP_SKIP);
    wire cycle_end = (phase_q == `DCP_PH_T7);
    // released only at cycle end so each wait cycle carries a full strobe
    wire release_wait = ready && cycle_end;
    wire skip_hit = skip_kind_sys_q ? sys_skip : unit_skip;

    // a skip issued past the strobe slot waits into the next cycle, so the
    // unit always gets its strobe before the response is taken
    assign skip_seen_d = in_skip && (skip_seen_q || strobe_slot);
    wire skip_end = in_skip && skip_seen_q && cycle_end;
    wire timing_a = (phase_q >= `DCP_PH_T5) || (phase_q == `DCP_PH_T0);
    wire timing_b = (phase_q >= `DCP_PH_T6) || (phase_q <= `DCP_PH_T3);
    wire timing_c = (phase_q == `DCP_PH_T7) || (phase_q <= `DCP_PH_T4);
    wire start_any = i_op_pot || i_op_pin || i_op_direct || i_op_skip;
    wire sel_decode = c_q[`DCP_SEL_B1] && c_q[`DCP_SEL_B17]
        && ~c_q[`DCP_SEL_B10];

    // next values of the registered outputs
    wire pot_wait_d = (state_d == OP_OUT_WAIT);
    wire pot_strobe_d = in_out_wait && strobe_slot;
    wire pin_strobe_d = in_in_wait && strobe_slot;
    wire direct_now = (state_q == OP_DIRECT);
    wire io_strobe_d = direct_now && (mode_q == MODE_IO);
    wire buffer_strobe_d = direct_now && (mode_q == MODE_BUFFER);
    wire system_strobe_d = direct_now && (mode_q == MODE_SYSTEM);
    wire skip_strobe_d = in_skip && strobe_slot;
    wire term_n_d = (state_q != OP_IN_DONE);
    wire busy_d = (state_d != OP_IDLE);
    wire done_d = (state_q != OP_IDLE) && (state_d == OP_IDLE);
    wire skip_next_d = skip_end && skip_hit;
    wire capture_in = in_in_wait && release_wait;
    // the plain connector passes the tape gap through, one clock late
    wire c_or_gap_d = i_companion_conn ? timing_c : i_tape_gap;

    sync_low u_ready (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin_n(i_external_ready_n),
        .o_active(ready)
    );
    sync_low u_unit_skip (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin_n(i_unit_skip_n),
        .o_active(unit_skip)
    );
    sync_low u_sys_skip (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin_n(i_system_skip_n),
        .o_active(sys_skip)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            OP_IDLE: begin
                if (i_op_pot) begin
                    state_d = OP_OUT_WAIT;
                end else if (i_op_pin) begin
                    state_d = OP_IN_WAIT;
                end else if (i_op_direct) begin
                    state_d = OP_DIRECT;
                end else if (i_op_skip) begin
                    state_d = OP_SKIP;
                end
            end
            OP_OUT_WAIT: begin
                if (release_wait) begin
                    state_d = OP_IDLE;
                end
            end
            OP_IN_WAIT: begin
                if (release_wait) begin
                    state_d = OP_IN_DONE;
                end
            end
            // response sampled late in the cycle so the unit sees the strobe
            OP_SKIP: begin
                if (skip_end) begin
                    state_d = OP_IDLE;
                end
            end
            default: begin
                state_d = OP_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= OP_IDLE;
            phase_q <= `DCP_PH_T0;
            skip_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_q + 3'h1;
            skip_seen_q <= skip_seen_d;
        end
    end

    // c lines only load when idle, so they hold through output wait
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            c_q <= `DCP_C_RST;
            mode_q <= MODE_IO;
            skip_kind_sys_q <= 1'b0;
        end else if (state_q == OP_IDLE && start_any) begin
            c_q <= i_c_word;
            mode_q <= i_direct_mode;
            skip_kind_sys_q <= (i_skip_kind == SKIP_SYSTEM);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pot_wait <= 1'b0;
            o_pot_strobe <= 1'b0;
            o_pin_strobe <= 1'b0;
            o_direct_io_mode_strobe <= 1'b0;
            o_direct_buffer_strobe <= 1'b0;
            o_direct_system_strobe <= 1'b0;
            o_direct_common_strobe <= 1'b0;
            o_skip_test_strobe <= 1'b0;
            o_pin_terminated_n <= 1'b1;
        end else begin
            o_pot_wait <= pot_wait_d;
            o_pot_strobe <= pot_strobe_d;
            o_pin_strobe <= pin_strobe_d;
            o_direct_common_strobe <= direct_now;
            o_direct_io_mode_strobe <= io_strobe_d;
            o_direct_buffer_strobe <= buffer_strobe_d;
            o_direct_system_strobe <= system_strobe_d;
            o_skip_test_strobe <= skip_strobe_d;
            o_pin_terminated_n <= term_n_d;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_phase_timing_a <= 1'b0;
            o_phase_timing_b <= 1'b0;
            o_phase_c_or_gap <= 1'b0;
            o_start_reset_out <= 1'b0;
            o_device_select <= 1'b0;
            o_c_lines <= `DCP_C_RST;
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_skip_next <= 1'b0;
            o_c_reg_in <= `DCP_C_RST;
        end else begin
            o_phase_timing_a <= timing_a;
            o_phase_timing_b <= timing_b;
            o_phase_c_or_gap <= c_or_gap_d;
            o_start_reset_out <= i_start_button;
            o_device_select <= sel_decode;
            o_c_lines <= c_q;
            o_busy <= busy_d;
            o_done <= done_d;
            o_skip_next <= skip_next_d;
            if (capture_in) begin
                o_c_reg_in <= ~i_in_data_n;
            end
        end
    end
endmodule : dcp_port

// [dcp_port_asserts.sv]
// output checks for the direct channel parallel port
// assumes a bind into dcp_port with one clock domain
`timescale 1ns/10ps
module dcp_port_asserts (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start_button,
    input wire logic o_pot_wait,
    input wire logic o_pot_strobe,
    input wire logic o_pin_strobe,
    input wire logic o_direct_io_mode_strobe,
    input wire logic o_direct_buffer_strobe,
    input wire logic o_direct_system_strobe,
    input wire logic o_direct_common_strobe,
    input wire logic o_phase_timing_a,
    input wire logic o_phase_timing_b,
    input wire logic o_pin_terminated_n,
    input wire logic o_start_reset_out,
    input wire logic o_device_select,
    input wire logic [23:0] o_c_lines
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    wire logic [2:0] mode_s = {o_direct_system_strobe,
        o_direct_buffer_strobe, o_direct_io_mode_strobe};
    a_mode_one: assert property (o_direct_common_strobe |->
        $onehot(mode_s)) else $error("mode strobe");
    a_mode_common: assert property (|mode_s |->
        o_direct_common_strobe) else $error("common strobe");
    // falls are used: the first high span after reset is short
    a_timing_a: assert property ($fell(o_phase_timing_a) |->
        !o_phase_timing_a[*4] ##1 o_phase_timing_a[*4])
        else $error("timing a");
    a_timing_b: assert property ($fell(o_phase_timing_b) |->
        !o_phase_timing_b[*2] ##1 o_phase_timing_b[*6])
        else $error("timing b");
    a_timing_ab: assert property ($fell(o_phase_timing_a) |->
        o_phase_timing_b[*3] ##1 !o_phase_timing_b) else $error("a to b");
    a_pot_gap: assert property (o_pot_strobe |->
        o_pot_wait ##1 !o_pot_strobe[*7]) else $error("pot strobe");
    a_pin_gap: assert property (o_pin_strobe |=>
        !o_pin_strobe[*7]) else $error("pin strobe");
    a_c_hold: assert property (o_pot_wait && $past(o_pot_wait, 2) |->
        $stable(o_c_lines)) else $error("c lines moved");
    a_term_pulse: assert property ($fell(o_pin_terminated_n) |=>
        o_pin_terminated_n) else $error("term pulse");
    a_start_out: assert property (i_start_button |=>
        o_start_reset_out) else $error("start out");
    a_select_dec: assert property ($stable(o_c_lines)[*2] |->
        o_device_select == (o_c_lines[1] & o_c_lines[17] & !o_c_lines[10]))
        else $error("select");
endmodule : dcp_port_asserts
bind dcp_port dcp_port_asserts chk_u (.*);

// [ext_unit_model.sv]
// far-side unit: ready after a set number of strobes, skip levels
// assumes the bench sets delay and responses before each instruction
`timescale 1ns/10ps
module ext_unit_model (
    input wire logic i_clk,
    input wire logic i_busy,
    input wire logic i_strobe,
    input wire logic [3:0] i_delay,
    input wire logic i_unit_resp,
    input wire logic i_sys_resp,
    output logic o_ready_n,
    output logic o_unit_skip_n,
    output logic o_system_skip_n
);
    logic [3:0] seen_q;
    initial begin
        seen_q = 4'h0;
        o_ready_n = 1'b1;
    end
    // ready stays low until the port drops busy
    always @(negedge i_clk) begin
        if (!i_busy) begin
            seen_q <= 4'h0;
            o_ready_n <= 1'b1;
        end else if (i_strobe) begin
            seen_q <= seen_q + 4'h1;
            o_ready_n <= (seen_q + 4'h1) < i_delay;
        end
    end
    assign o_unit_skip_n = !i_unit_resp;
    assign o_system_skip_n = !i_sys_resp;
endmodule : ext_unit_model

// [sync_low.sv]
// two-flop synchroniser for an active-low input, idle high after reset
// assumes the input is a level from outside the clock domain
`timescale 1ns/10ps
module sync_low (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin_n,
    output logic o_active
);
    logic meta_q;
    logic stable_q;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_q <= 1'b1;
            stable_q <= 1'b1;
        end else begin
            meta_q <= i_pin_n;
            stable_q <= meta_q;
        end
    end
    assign o_active = ~stable_q;
endmodule : sync_low

// [testbench.sv]
// bench for dcp_port with the far-side unit model
// assumes a 20 MHz clock; inputs change on falling edges
`timescale 1ns/10ps
module testbench;
    import dcp_pkg::*;
    logic i_clk, i_rst, op_pot, op_pin, op_dir, op_skip, conn, gap, button;
    logic u_resp, s_resp, ready_n, u_n, s_n, busy, done, skip_nx, pw, ps;
    logic pn, s_io, s_bu, s_sy, s_co, ta, tmb, tcg, term_n;
    logic skip_stb, start_o, sel;
    logic [23:0] c_word, in_n, c_lines, c_in;
    logic [3:0] delay;
    direct_mode_t mode;
    skip_kind_t kind;
    int n_errors = 0;
    int num_checks = 0;
    int cnt[8];
    dcp_port dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_op_pot(op_pot),
        .i_op_pin(op_pin), .i_op_direct(op_dir), .i_op_skip(op_skip),
        .i_direct_mode(mode), .i_skip_kind(kind), .i_c_word(c_word),
        .i_companion_conn(conn), .i_tape_gap(gap), .i_start_button(button),
        .i_external_ready_n(ready_n), .i_unit_skip_n(u_n),
        .i_system_skip_n(s_n), .i_in_data_n(in_n), .o_busy(busy),
        .o_done(done), .o_skip_next(skip_nx), .o_c_reg_in(c_in),
        .o_pot_wait(pw), .o_pot_strobe(ps), .o_pin_strobe(pn),
        .o_direct_io_mode_strobe(s_io), .o_direct_buffer_strobe(s_bu),
        .o_direct_system_strobe(s_sy), .o_direct_common_strobe(s_co),
        .o_phase_timing_a(ta), .o_phase_timing_b(tmb),
        .o_phase_c_or_gap(tcg), .o_pin_terminated_n(term_n),
        .o_skip_test_strobe(skip_stb), .o_start_reset_out(start_o),
        .o_device_select(sel), .o_c_lines(c_lines));
    ext_unit_model unit_u (.i_clk(i_clk), .i_busy(busy), .i_strobe(ps | pn),
        .i_delay(delay), .i_unit_resp(u_resp), .i_sys_resp(s_resp),
        .o_ready_n(ready_n), .o_unit_skip_n(u_n), .o_system_skip_n(s_n));
    task automatic chk(input string what, input logic [23:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic close_out;
        $display("errors %0d checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out
    // one instruction: pulse its start, count strobes until done
    task automatic run(input logic [3:0] ops);
        int k;
        foreach (cnt[j]) cnt[j] = 0;
        @(negedge i_clk);
        {op_pot, op_pin, op_dir, op_skip} = ops;
        @(negedge i_clk);
        {op_pot, op_pin, op_dir, op_skip} = 4'h0;
        for (k = 0; k < 300 && done !== 1'b1; k++) begin
            @(negedge i_clk);
            cnt[0] += ps; cnt[1] += pn; cnt[2] += s_co; cnt[3] += !term_n;
            cnt[4] += skip_stb; cnt[5] += skip_nx; cnt[6] += pw;
            if (s_co === 1'b1) cnt[7] = {s_sy, s_bu, s_io};
        end
        chk("done", 1, k < 300);
    endtask : run
    task automatic t_pot;
        for (int d = 1; d < 4; d += 2) begin
            delay = d;
            c_word = (d == 1) ? 24'h020002 : 24'h020402;
            run(4'h8);
            chk("pot strobes", d, cnt[0]);
            chk("wait seen", 1, cnt[6] > 0);
            chk("wait left", 0, pw);
            chk("c lines", c_word, c_lines);
            chk("select", d == 1, sel);
        end
    endtask : t_pot
    task automatic t_pin;
        delay = 2;
        in_n = ~24'hA5C3E1;
        run(4'h4);
        repeat (2) @(negedge i_clk) cnt[3] += !term_n;
        chk("pin strobes", 2, cnt[1]);
        chk("c in", 24'hA5C3E1, c_in);
        chk("term lows", 1, cnt[3]);
    endtask : t_pin
    task automatic t_direct;
        for (int m = 0; m < 3; m++) begin
            mode = direct_mode_t'(m);
            run(4'h2);
            chk("common", 1, cnt[2]);
            chk("mode", 1 << m, cnt[7]);
        end
    endtask : t_direct
    task automatic t_skip;
        for (int j = 0; j < 4; j++) begin
            kind = skip_kind_t'(j[1]);
            u_resp = j[0];
            s_resp = !j[0];
            run(4'h1);
            chk("skip strobes", 1, cnt[4]);
            chk("skip", j[1] ? !j[0] : j[0], cnt[5]);
        end
    endtask : t_skip
    task automatic t_misc;
        foreach (cnt[j]) cnt[j] = 0;
        repeat (16) @(negedge i_clk) begin
            cnt[0] += ta; cnt[1] += tmb; cnt[2] += tcg;
        end
        chk("timing a", 8, cnt[0]);
        chk("timing b", 12, cnt[1]);
        chk("timing c", 12, cnt[2]);
        conn = 0;
        gap = 1;
        button = 1;
        repeat (3) @(negedge i_clk);
        chk("gap", 1, tcg);
        chk("start", 1, start_o);
        button = 0;
        gap = 0;
        repeat (3) @(negedge i_clk);
        chk("gap low", 0, tcg);
        chk("start low", 0, start_o);
    endtask : t_misc
    initial begin
        i_clk = 0;
        forever #25 i_clk = ~i_clk;
    end
    initial begin
        #2000000;
        n_errors++;
        close_out();
    end
    initial begin
        {op_pot, op_pin, op_dir, op_skip, gap, button, u_resp, s_resp} = 0;
        {c_word, in_n, delay} = 0;
        conn = 1;
        mode = MODE_IO;
        kind = SKIP_UNIT;
        i_rst = 1;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk) i_rst = 0;
        t_pot();
        t_pin();
        t_direct();
        t_skip();
        t_misc();
        close_out();
    end
endmodule : testbench
